// ### rtl/sarseq_regs.svh
// Constants of the successive-approximation converter sequencer.
// Assumes inclusion by the package and the design modules only.
`ifndef SARSEQ_REGS_SVH
`define SARSEQ_REGS_SVH

// Channel map: ten external pins, then the band-gap channel.
`define SARSEQ_EXT_CHANNELS 4'ha
`define SARSEQ_BANDGAP_CH 4'ha
`define SARSEQ_CH_WIDTH 4

// Resolution field encodings.
`define SARSEQ_RES_8 2'h0
`define SARSEQ_RES_9 2'h1
`define SARSEQ_RES_10 2'h2

// Conversion lengths in converter clock periods.
`define SARSEQ_CONV_8BIT 4'hd
`define SARSEQ_CONV_9BIT 4'he
`define SARSEQ_CONV_10BIT 4'hf

// Period index of the first successive-approximation step.
`define SARSEQ_FIRST_BIT_PERIOD 4'h3
// Period index whose decision lands on result bit 0 at full resolution.
`define SARSEQ_LSB_PERIOD 4'hc

// Result and divider widths.
`define SARSEQ_RESULT_WIDTH 10
`define SARSEQ_DIV_WIDTH 7
`define SARSEQ_DIV_SEL_WIDTH 3

`endif

// ### rtl/sarseq_pkg.sv
// Types shared by the converter sequencer and its clock divider.
// Assumes sarseq_regs.svh is on the include path.
`include "sarseq_regs.svh"

package sarseq_pkg;

  typedef enum logic {
    SARSEQ_IDLE,
    SARSEQ_BUSY
  } sarseq_state_t;

  typedef struct packed {
    sarseq_state_t state;
    logic [3:0] period;
    logic [1:0] res;
    logic [`SARSEQ_DIV_SEL_WIDTH-1:0] div_sel;
    logic [`SARSEQ_CH_WIDTH-1:0] ch;
    logic [`SARSEQ_RESULT_WIDTH-1:0] approx;
    logic done;
    logic irq;
    logic [7:0] rh;
    logic [7:0] rl;
  } sarseq_core_t;

  typedef struct packed {
    logic [`SARSEQ_DIV_WIDTH-1:0] count;
  } sarseq_div_t;

endpackage

// ### rtl/sarseq_clk_div.sv
// Power-of-two divider giving one enable pulse per converter clock period.
// Assumes one system clock; the restart input aligns periods to a start.
`include "sarseq_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module sarseq_clk_div
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Control.
  input wire logic restart_in,
  input wire logic [`SARSEQ_DIV_SEL_WIDTH-1:0] div_sel_in,
  // Enable pulse.
  output logic tick_out
);

  sarseq_pkg::sarseq_div_t d_reg;
  sarseq_pkg::sarseq_div_t d_next;
  logic [`SARSEQ_DIV_WIDTH-1:0] limit;

  // Terminal count is the divide ratio minus one.
  assign limit = `SARSEQ_DIV_WIDTH'((8'h01 << div_sel_in) - 8'h01);
  assign tick_out = !restart_in && (d_reg.count == limit);

  always_comb
  begin
    d_next = d_reg;
    if (restart_in || d_reg.count == limit)
    begin
      d_next.count = '0;
    end
    else
    begin
      d_next.count = d_reg.count + `SARSEQ_DIV_WIDTH'(1);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      d_reg <= '0;
    end
    else
    begin
      d_reg <= d_next;
    end
  end

endmodule // sarseq_clk_div

`default_nettype wire

// ### rtl/sarseq_core.sv
// Sequencer for a successive-approximation converter: channel, resolution,
// converter clock, start/done, completion request and result bytes.
// Assumes the analog mux, hold switch, DAC and comparator sit outside.
`include "sarseq_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module sarseq_core
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Control settings.
  input wire logic adc_enable_in,
  input wire logic [`SARSEQ_CH_WIDTH-1:0] chan_sel_in,
  input wire logic [1:0] res_sel_in,
  input wire logic [`SARSEQ_DIV_SEL_WIDTH-1:0] div_sel_in,
  input wire logic start_in,
  // Interrupt control.
  input wire logic irq_enable_in,
  input wire logic global_irq_enable_in,
  input wire logic irq_clear_in,
  // Analog front end.
  input wire logic comp_in,
  output logic [`SARSEQ_CH_WIDTH-1:0] chan_out,
  output logic sample_out,
  output logic [`SARSEQ_RESULT_WIDTH-1:0] dac_code_out,
  // Status and result.
  output logic busy_out,
  output logic start_done_out,
  output logic irq_flag_out,
  output logic irq_out,
  output logic [7:0] result_high_out,
  output logic [7:0] result_low_out
);

  sarseq_pkg::sarseq_core_t c_reg;
  sarseq_pkg::sarseq_core_t c_next;
  logic tick;
  logic busy;
  logic sar_step;
  logic [3:0] last_period;
  logic [3:0] bit_idx;
  logic [`SARSEQ_RESULT_WIDTH-1:0] trial;

  assign busy = (c_reg.state == sarseq_pkg::SARSEQ_BUSY);

  sarseq_clk_div sarseq_clk_div_inst
  (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .restart_in(!busy),
    .div_sel_in(c_reg.div_sel),
    .tick_out(tick)
  );

  // Final period index depends on the latched resolution.
  always_comb
  begin
    unique case (c_reg.res)
      `SARSEQ_RES_8: last_period = `SARSEQ_CONV_8BIT - 4'h1;
      `SARSEQ_RES_9: last_period = `SARSEQ_CONV_9BIT - 4'h1;
      default: last_period = `SARSEQ_CONV_10BIT - 4'h1;
    endcase
  end

  // One bit is decided per period, most significant first.
  assign bit_idx = `SARSEQ_LSB_PERIOD - c_reg.period;
  assign sar_step = busy && (c_reg.period >= `SARSEQ_FIRST_BIT_PERIOD)
    && (c_reg.period <= last_period - 4'h2);
  assign trial = sar_step ? (c_reg.approx | (`SARSEQ_RESULT_WIDTH'(1) << bit_idx))
    : c_reg.approx;

  always_comb
  begin
    c_next = c_reg;
    unique case (c_reg.state)
      sarseq_pkg::SARSEQ_IDLE:
      begin
        if (adc_enable_in && start_in)
        begin
          c_next.state = sarseq_pkg::SARSEQ_BUSY;
          c_next.period = 4'h0;
          c_next.approx = '0;
          c_next.done = 1'b0;
          c_next.div_sel = div_sel_in;
          c_next.res = (res_sel_in > `SARSEQ_RES_10) ? `SARSEQ_RES_10 : res_sel_in;
          c_next.ch = (chan_sel_in > `SARSEQ_BANDGAP_CH) ? `SARSEQ_BANDGAP_CH
            : chan_sel_in;
        end
      end
      sarseq_pkg::SARSEQ_BUSY:
      begin
        if (!adc_enable_in)
        begin
          c_next.state = sarseq_pkg::SARSEQ_IDLE;
        end
        else if (tick)
        begin
          if (sar_step)
          begin
            c_next.approx[bit_idx] = comp_in;
          end
          if (c_reg.period == last_period)
          begin
            c_next.state = sarseq_pkg::SARSEQ_IDLE;
            c_next.done = 1'b1;
            c_next.irq = 1'b1;
            c_next.rh = c_reg.approx[9:2];
            c_next.rl = {c_reg.approx[1:0], 6'h00};
          end
          else
          begin
            c_next.period = c_reg.period + 4'h1;
          end
        end
      end
    endcase
    // A completion in the clearing cycle keeps the request set.
    if (irq_clear_in && !(busy && adc_enable_in && tick && c_reg.period == last_period))
    begin
      c_next.irq = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      c_reg <= '0;
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  assign chan_out = c_reg.ch;
  assign sample_out = busy && (c_reg.period == 4'h0);
  assign dac_code_out = trial;
  assign busy_out = busy;
  assign start_done_out = c_reg.done;
  assign irq_flag_out = c_reg.irq;
  assign irq_out = c_reg.irq && irq_enable_in && global_irq_enable_in;
  assign result_high_out = c_reg.rh;
  assign result_low_out = c_reg.rl;

  // Helper counters for the checks below.
  logic [11:0] busy_cycles;
  logic [7:0] sample_cycles;
  logic [11:0] expect_cycles;
  logic [3:0] conv_len;
  assign conv_len = last_period + 4'h1;
  assign expect_cycles = 12'(conv_len) << c_reg.div_sel;

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      busy_cycles <= '0;
      sample_cycles <= '0;
    end
    else
    begin
      busy_cycles <= busy ? busy_cycles + 12'h001 : 12'h000;
      sample_cycles <= sample_out ? sample_cycles + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  chan_in_range_a: assert property (chan_out <= `SARSEQ_BANDGAP_CH)
    else $error("Channel select beyond band-gap channel.");
  sample_first_a: assert property ($rose(busy) |-> sample_out && !sar_step)
    else $error("Conversion did not begin with acquisition.");
  acq_one_period_a: assert property ($fell(sample_out) && busy |->
    (12'($past(sample_cycles)) + 12'h001) == (12'h001 << c_reg.div_sel))
    else $error("Acquisition length is not one converter clock period.");
  busy_reads_zero_a: assert property (busy |-> !start_done_out)
    else $error("Start/done read one during conversion.");
  conv_length_a: assert property (busy && adc_enable_in && tick && c_reg.period == last_period
    |-> busy_cycles + 12'h001 == expect_cycles ##1 start_done_out)
    else $error("Conversion length does not match resolution.");
  done_sets_irq_a: assert property ($rose(start_done_out) |-> irq_flag_out)
    else $error("Completion did not raise the request.");
  irq_gated_a: assert property (irq_out |-> irq_enable_in && global_irq_enable_in)
    else $error("Interrupt raised while disabled.");
  result_hold_a: assert property (busy && $past(busy) |->
    $stable(result_high_out) && $stable(result_low_out))
    else $error("Result changed before the last bit.");
  low_byte_a: assert property (start_done_out |-> result_low_out[5:0] == 6'h00)
    else $error("Low byte carries bits below the result.");
  res8_low_a: assert property ($rose(start_done_out) && c_reg.res == `SARSEQ_RES_8
    |-> result_low_out == 8'h00)
    else $error("8-bit result spilled into low byte.");
  disable_stops_a: assert property (!adc_enable_in |=> !busy)
    else $error("Converter kept running while disabled.");
  irq_clear_a: assert property (irq_clear_in
    && !(busy && adc_enable_in && tick && c_reg.period == last_period) |=> !irq_flag_out)
    else $error("Request flag not cleared.");
  set_wins_a: assert property (irq_clear_in && busy && adc_enable_in && tick
    && c_reg.period == last_period |=> irq_flag_out)
    else $error("Clear in the completion cycle dropped the request.");
  msb_first_a: assert property (sar_step && c_reg.period == `SARSEQ_FIRST_BIT_PERIOD
    |-> dac_code_out == 10'h200)
    else $error("First trial is not the most significant bit.");

endmodule // sarseq_core

`default_nettype wire

// ### testbench/sar_adc_sequencer_tb_top.sv
// Self-checking bench for the converter sequencer: timing, results, request, abort.
// Assumes the rtl files are compiled first; the bench plays an ideal comparator.
`timescale 1ns/100ps
`default_nettype none

module sar_adc_sequencer_tb_top;
  logic ref_clk_in;
  logic rstn_in;
  logic adc_enable_in;
  logic [3:0] chan_sel_in;
  logic [1:0] res_sel_in;
  logic [2:0] div_sel_in;
  logic start_in;
  logic irq_enable_in;
  logic global_irq_enable_in;
  logic irq_clear_in;
  logic comp_in;
  logic [3:0] chan_out;
  logic sample_out;
  logic [9:0] dac_code_out;
  logic busy_out;
  logic start_done_out;
  logic irq_flag_out;
  logic irq_out;
  logic [7:0] result_high_out;
  logic [7:0] result_low_out;
  logic [9:0] vin;
  logic [7:0] exp_h;
  logic [7:0] exp_l;
  int n_mismatch;
  int total_checks;

  sarseq_core sarseq_core_inst (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .adc_enable_in(adc_enable_in),
    .chan_sel_in(chan_sel_in), .res_sel_in(res_sel_in), .div_sel_in(div_sel_in),
    .start_in(start_in), .irq_enable_in(irq_enable_in),
    .global_irq_enable_in(global_irq_enable_in), .irq_clear_in(irq_clear_in),
    .comp_in(comp_in), .chan_out(chan_out), .sample_out(sample_out),
    .dac_code_out(dac_code_out), .busy_out(busy_out), .start_done_out(start_done_out),
    .irq_flag_out(irq_flag_out), .irq_out(irq_out),
    .result_high_out(result_high_out), .result_low_out(result_low_out)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  // Ideal comparator: high while the input is at or above the trial code.
  always @(negedge ref_clk_in)
    comp_in <= (vin >= dac_code_out);

  task automatic chk(input logic [15:0] seen, input logic [15:0] expv, input string what);
    total_checks++;
    if (seen !== expv)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One-cycle start pulse, entered and left just after a falling edge.
  task automatic kick;
    start_in = 1'b1;
    @(negedge ref_clk_in);
    start_in = 1'b0;
  endtask

  task automatic conv(input logic [1:0] r, input logic [2:0] d, input logic [9:0] v);
    int dd;
    int nn;
    dd = 1 << d;
    nn = (r == 2'h0) ? 13 : (r == 2'h1) ? 14 : 15;
    res_sel_in = r;
    div_sel_in = d;
    vin = v;
    start_in = 1'b1;
    @(negedge ref_clk_in);
    chk(busy_out, 1'b1, "busy");
    chk(start_done_out, 1'b0, "done cleared");
    chk(sample_out, 1'b1, "sample open");
    chk(chan_out, (chan_sel_in > 4'ha) ? 4'ha : chan_sel_in, "channel");
    res_sel_in = 2'h3 - r;
    div_sel_in = 3'h7 - d;
    @(negedge ref_clk_in);
    start_in = 1'b0;
    repeat (dd - 1) @(negedge ref_clk_in);
    chk(sample_out, 1'b0, "sample closed");
    repeat (nn * dd - dd - 1) @(negedge ref_clk_in);
    chk(start_done_out, 1'b0, "done early");
    chk({result_high_out, result_low_out}, {exp_h, exp_l}, "result held");
    irq_clear_in = 1'b1;
    @(negedge ref_clk_in);
    irq_clear_in = 1'b0;
    chk(start_done_out, 1'b1, "done");
    chk(busy_out, 1'b0, "idle");
    exp_h = v[9:2];
    exp_l = (r == 2'h0) ? 8'h00 : (r == 2'h1) ? {v[1], 7'h00} : {v[1:0], 6'h00};
    chk({result_high_out, result_low_out}, {exp_h, exp_l}, "result");
    chk(irq_flag_out, 1'b1, "request set wins");
  endtask

  initial
  begin
    rstn_in = 1'b0;
    adc_enable_in = 1'b0;
    chan_sel_in = 4'h3;
    res_sel_in = 2'h2;
    div_sel_in = 3'h0;
    start_in = 1'b0;
    irq_enable_in = 1'b0;
    global_irq_enable_in = 1'b0;
    irq_clear_in = 1'b0;
    vin = 10'h000;
    exp_h = 8'h00;
    exp_l = 8'h00;
    n_mismatch = 0;
    total_checks = 0;
    repeat (2) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    chk(start_done_out, 1'b0, "reset done");
    adc_enable_in = 1'b1;
    @(negedge ref_clk_in);
    for (int i = 0; i < 8; i++)
    begin
      chan_sel_in = 4'(i + 8);
      conv(i[1:0], i[2:0], 10'(i * 137 + 5));
    end
    conv(2'h2, 3'h0, 10'h3ff);
    conv(2'h2, 3'h0, 10'h000);
    $display("test sweep done");
    for (int k = 0; k < 4; k++)
    begin
      irq_enable_in = k[0];
      global_irq_enable_in = k[1];
      @(negedge ref_clk_in);
      chk(irq_out, k == 3, "request gate");
    end
    irq_clear_in = 1'b1;
    @(negedge ref_clk_in);
    irq_clear_in = 1'b0;
    chk({irq_flag_out, irq_out}, 2'h0, "request cleared");
    $display("test request done");
    kick();
    repeat (3) @(negedge ref_clk_in);
    adc_enable_in = 1'b0;
    @(negedge ref_clk_in);
    chk({busy_out, start_done_out}, 2'h0, "abort");
    kick();
    repeat (20) @(negedge ref_clk_in);
    chk({busy_out, start_done_out, irq_flag_out}, 3'h0, "disabled");
    chk({result_high_out, result_low_out}, {exp_h, exp_l}, "result kept");
    adc_enable_in = 1'b1;
    conv(2'h1, 3'h1, 10'h1b6);
    chk(irq_out, 1'b1, "request out");
    $display("test abort done");
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule // sar_adc_sequencer_tb_top

`default_nettype wire
